// [drive_ctrl_pkg.sv]
// Purpose: shared constants and types for the drive serial control and status block
// Assumes: 16-bit status word, control word and references
// Notes: settings come from the local control panel port only
package drive_ctrl_pkg;
  localparam int WORD_W = 16;
  // status word bit positions
  localparam int ST_IN_RANGE = 10;
  localparam int ST_RUNNING = 11;
  localparam int ST_SPARE = 12;
  localparam int ST_VOLT_WARN = 13;
  localparam int ST_CUR_LIMIT = 14;
  localparam int ST_THERMAL = 15;
  // control word bit positions
  localparam int CW_COAST_N = 3;
  localparam int CW_DATA_VALID = 10;
  // pin synchroniser bit positions and reset pattern
  localparam int SY_VOLT_LOW = 1;
  localparam int SY_VOLT_HIGH = 2;
  localparam int SY_MOTOR_HOT = 3;
  localparam int SY_CONV_HOT = 4;
  localparam int SY_THERM_HOT = 5;
  localparam int SY_COAST_N = 6;
  localparam logic [9:0] SYNC_RESET = 10'h040;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  // reference scaling
  localparam logic [15:0] REF_FULL = 16'h4000;
  localparam int REF_SHIFT = 14;
  // protocol codes
  typedef enum logic [1:0] {
    PROTO_NATIVE = 2'b00,
    PROTO_BLDG_A = 2'b01,
    PROTO_BLDG_B = 2'b10,
    PROTO_MODBUS = 2'b11
  } proto_t;
  // command source selector codes
  typedef enum logic [1:0] {
    SRC_TERMINAL = 2'b00,
    SRC_SERIAL = 2'b01,
    SRC_AND = 2'b10,
    SRC_OR = 2'b11
  } src_sel_t;
  // bit-rate codes
  localparam logic [2:0] BAUD_300 = 3'h0;
  localparam logic [2:0] BAUD_4800 = 3'h4;
  localparam logic [2:0] BAUD_9600 = 3'h5;
  // address limits and defaults
  localparam logic [7:0] ADDR_DEFAULT = 8'h01;
  localparam logic [7:0] ADDR_MAX_NATIVE = 8'h7E;
  localparam logic [7:0] ADDR_MAX_BLDG_A = 8'hFF;
  localparam logic [7:0] ADDR_MAX_BLDG_B = 8'h62;
  localparam logic [7:0] ADDR_MAX_MODBUS = 8'hF7;
  localparam logic [15:0] TRIP_DELAY_DEFAULT = 16'h0064;
endpackage

// [coast_if.sv]
// Purpose: carries the coasting inputs and result between the top and the combiner
// Assumes: single clock domain
// Notes: inputs are active low
`timescale 1ns/1ns
`default_nettype none
interface coast_if;
  logic term_n;
  logic serial_n;
  drive_ctrl_pkg::src_sel_t sel;
  logic coast;
  modport top (output term_n, output serial_n, output sel, input coast);
  modport comb (input term_n, input serial_n, input sel, output coast);
endinterface
`default_nettype wire

// [coast_combiner.sv]
// Purpose: combines terminal and serial coasting requests by the selector
// Assumes: both inputs already synchronised
// Notes: result is combinational; the top registers it
`timescale 1ns/1ns
`default_nettype none
module coast_combiner (
  coast_if.comb cif // coasting request group
);
  // selector table for the active-low requests
  always_comb begin
    unique case (cif.sel)
      drive_ctrl_pkg::SRC_TERMINAL: cif.coast = ~cif.term_n;
      drive_ctrl_pkg::SRC_SERIAL: cif.coast = ~cif.serial_n;
      drive_ctrl_pkg::SRC_AND: cif.coast = ~cif.term_n & ~cif.serial_n;
      drive_ctrl_pkg::SRC_OR: cif.coast = ~(cif.term_n & cif.serial_n);
    endcase
  end
endmodule
`default_nettype wire

// [drive_serial_control_status.sv]
// Purpose: status word, reference scaling, protocol settings and coasting for serial control
// Assumes: measurement flags are pins; settings come from the local control panel
// Notes: all outputs registered; serial writes to address and bit rate are refused
// Overview of operation
// - bit 10 high while frequency strictly between low and high limits
// - bit 11 high with a start signal or frequency above zero
// - bit 12 has no meaning and reads zero
// - bit 13 high when link voltage is too low or too high
// - bit 14 high above current limit; trip after configured delay
// - bit 15 high on motor, converter or thermistor overtemperature
// - reference is a 16-bit signed value, 16384 means 100 percent
// - reference 0 maps to minimum, 16384 to maximum, linear between
// - negative reference commands reverse rotation at same magnitude
// - output frequency reported as 16-bit signed value, 16384 is 100 percent
// - reported 0 is low frequency limit, 16384 is high limit
// - protocol codes: native default, two building protocols, Modbus RTU
// - address range depends on protocol; default address is one
// - station address cannot be changed over the serial link
// - bit-rate codes 0 to 5 for 300 to 9600, default 9600
// - bit rate cannot be written over the serial link
// - allowed bit rates are limited per protocol
// - command source selector: terminal, serial, both, either
// - coasting terminal and control-word bit 3 are active low
// - coasting follows the selector, default code 3
// - control word ignored while its bit 10 is zero
// - effective coasting switches the output stage off at once
`timescale 1ns/1ns
`default_nettype none
module drive_serial_control_status (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [9:0] status_low_in, // lower status bits from other logic
  input wire logic [15:0] out_freq, // present output frequency, unsigned units
  input wire logic [15:0] freq_low_limit, // low output frequency limit
  input wire logic [15:0] freq_high_limit, // high output frequency limit
  input wire logic start_active, // start signal present
  input wire logic volt_low_pin, // link voltage too low, pin
  input wire logic volt_high_pin, // link voltage too high, pin
  input wire logic [15:0] out_current, // measured output current
  input wire logic [15:0] output_current_limit, // configured current limit
  input wire logic [15:0] trip_delay_cycles, // overcurrent trip delay in cycles
  input wire logic trip_reset, // clears the overcurrent trip
  input wire logic motor_hot_pin, // motor overtemperature, pin
  input wire logic conv_hot_pin, // converter overtemperature, pin
  input wire logic thermistor_hot_pin, // thermistor overtemperature, pin
  input wire logic cw_valid, // one-cycle strobe: new control word
  input wire logic [15:0] ctrl_word, // received control word
  input wire logic [15:0] serial_ref, // received signed reference
  input wire logic [15:0] ref_min, // configured minimum reference
  input wire logic [15:0] ref_max, // configured maximum reference
  input wire logic coast_term_n_pin, // coasting terminal, active low pin
  input wire logic [1:0] coast_sel, // coasting source selector
  input wire logic panel_wr, // one-cycle strobe: write from local control panel
  input wire logic serial_wr, // one-cycle strobe: setting write over serial link
  input wire logic [1:0] wr_protocol, // protocol code to write
  input wire logic [7:0] wr_address, // station address to write
  input wire logic [2:0] wr_baud, // bit-rate code to write
  output logic [15:0] status_word, // assembled status word
  output logic [15:0] freq_report, // scaled signed output frequency
  output logic [15:0] ref_value, // scaled reference magnitude
  output logic reverse, // reference commands reverse rotation
  output logic coast_active, // effective coasting request
  output logic stage_enable, // output stage on
  output logic oc_trip, // overcurrent trip latched
  output logic [1:0] protocol, // active protocol code
  output logic [7:0] station_addr, // active station address
  output logic [2:0] baud_code, // active bit-rate code
  output logic wr_reject // one-cycle pulse: write refused
);
  typedef struct packed {
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic coast_serial_n;
    logic [15:0] oc_count;
    logic oc_trip;
    logic [15:0] status;
    logic [15:0] freq_rep;
    logic [15:0] ref_val;
    logic rev;
    logic coast;
    logic stage_en;
    drive_ctrl_pkg::proto_t proto;
    logic [7:0] addr;
    logic [2:0] baud;
    logic rej;
  } state_t;

  state_t st_q;
  state_t st_d;
  coast_if cif ();

  // address limit check for a protocol
  function automatic logic addr_ok(input logic [1:0] p, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    unique case (drive_ctrl_pkg::proto_t'(p))
      drive_ctrl_pkg::PROTO_NATIVE: begin
        ok = (a <= drive_ctrl_pkg::ADDR_MAX_NATIVE);
      end
      drive_ctrl_pkg::PROTO_BLDG_A: begin
        ok = (a != drive_ctrl_pkg::ADDR_ZERO) &&
             (a <= drive_ctrl_pkg::ADDR_MAX_BLDG_A);
      end
      drive_ctrl_pkg::PROTO_BLDG_B: begin
        ok = (a <= drive_ctrl_pkg::ADDR_MAX_BLDG_B);
      end
      drive_ctrl_pkg::PROTO_MODBUS: begin
        ok = (a != drive_ctrl_pkg::ADDR_ZERO) &&
             (a <= drive_ctrl_pkg::ADDR_MAX_MODBUS);
      end
    endcase
    return ok;
  endfunction

  // bit-rate check for a protocol
  function automatic logic baud_ok(input logic [1:0] p, input logic [2:0] b);
    logic ok;
    ok = 1'b0;
    if (b <= drive_ctrl_pkg::BAUD_9600) begin
      unique case (drive_ctrl_pkg::proto_t'(p))
        drive_ctrl_pkg::PROTO_NATIVE: begin
          ok = (b >= drive_ctrl_pkg::BAUD_300);
        end
        drive_ctrl_pkg::PROTO_BLDG_A: begin
          ok = (b == drive_ctrl_pkg::BAUD_9600);
        end
        drive_ctrl_pkg::PROTO_BLDG_B: begin
          ok = (b >= drive_ctrl_pkg::BAUD_4800);
        end
        drive_ctrl_pkg::PROTO_MODBUS: begin
          ok = 1'b1; // every listed code
        end
      endcase
    end
    return ok;
  endfunction

  // linear scale of v within lo..hi to 0..16384, zero at or below lo, not limited above hi
  function automatic logic [15:0] to_frac(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [31:0] num;
    logic [15:0] span;
    logic [15:0] res;
    num = 32'h0;
    span = hi - lo;
    res = 16'h0000;
    if (v > lo && span != 16'h0000) begin
      num = {16'h0000, v - lo} << drive_ctrl_pkg::REF_SHIFT;
      res = 16'(num / {16'h0000, span});
    end
    return res;
  endfunction

  // current above the configured limit, used by timer and status
  function automatic logic over_limit(input logic [15:0] cur, input logic [15:0] lim);
    return cur > lim;
  endfunction

  // magnitude of a signed reference; the most negative code wraps
  function automatic logic [15:0] ref_mag(input logic [15:0] r);
    logic [15:0] m;
    m = r;
    if (r[drive_ctrl_pkg::WORD_W-1]) begin
      m = 16'h0000 - r;
    end
    return m;
  endfunction

  // linear map of a magnitude onto lo..hi, full scale at 16384
  function automatic logic [15:0] ref_scale(input logic [15:0] m, input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [31:0] p;
    p = ({16'h0000, m} * {16'h0000, hi - lo}) >> drive_ctrl_pkg::REF_SHIFT;
    return lo + p[15:0];
  endfunction

  // status word from level inputs and the synchronised pins
  function automatic logic [15:0] status_next(input logic [9:0] low, input logic [15:0] f,
                                              input logic [15:0] lo, input logic [15:0] hi,
                                              input logic run, input logic [9:0] sy,
                                              input logic over);
    logic [15:0] s;
    s = 16'h0000;
    s[drive_ctrl_pkg::ST_IN_RANGE-1:0] = low;
    s[drive_ctrl_pkg::ST_IN_RANGE] = (f > lo) && (f < hi);
    s[drive_ctrl_pkg::ST_RUNNING] = run || (f != 16'h0000);
    s[drive_ctrl_pkg::ST_SPARE] = 1'b0;
    s[drive_ctrl_pkg::ST_VOLT_WARN] = sy[drive_ctrl_pkg::SY_VOLT_LOW] |
                                      sy[drive_ctrl_pkg::SY_VOLT_HIGH];
    s[drive_ctrl_pkg::ST_CUR_LIMIT] = over;
    s[drive_ctrl_pkg::ST_THERMAL] =
      |sy[drive_ctrl_pkg::SY_THERM_HOT:drive_ctrl_pkg::SY_MOTOR_HOT];
    return s;
  endfunction

  // coasting request group towards the combiner
  assign cif.term_n = st_q.sync2[drive_ctrl_pkg::SY_COAST_N];
  assign cif.serial_n = st_q.coast_serial_n;
  assign cif.sel = drive_ctrl_pkg::src_sel_t'(coast_sel);

  coast_combiner u_coast (
    .cif(cif)
  );

  // next-state logic for status, scaling, settings and coasting
  always_comb begin
    logic [15:0] mag;
    logic over;
    logic [2:0] nb;
    mag = 16'h0000;
    over = over_limit(out_current, output_current_limit);
    nb = 3'h0;
    st_d = st_q;
    st_d.rej = 1'b0;
    // two-stage sync of pin inputs
    st_d.sync1 = '0;
    st_d.sync1[drive_ctrl_pkg::SY_VOLT_LOW] = volt_low_pin;
    st_d.sync1[drive_ctrl_pkg::SY_VOLT_HIGH] = volt_high_pin;
    st_d.sync1[drive_ctrl_pkg::SY_MOTOR_HOT] = motor_hot_pin;
    st_d.sync1[drive_ctrl_pkg::SY_CONV_HOT] = conv_hot_pin;
    st_d.sync1[drive_ctrl_pkg::SY_THERM_HOT] = thermistor_hot_pin;
    st_d.sync1[drive_ctrl_pkg::SY_COAST_N] = coast_term_n_pin;
    st_d.sync2 = st_q.sync1;
    // control word only used when its valid bit is set
    if (cw_valid && ctrl_word[drive_ctrl_pkg::CW_DATA_VALID]) begin
      st_d.coast_serial_n = ctrl_word[drive_ctrl_pkg::CW_COAST_N];
      // reference sign selects direction, magnitude scaled
      st_d.rev = serial_ref[drive_ctrl_pkg::WORD_W-1];
      mag = ref_mag(serial_ref);
      st_d.ref_val = ref_scale(mag, ref_min, ref_max);
    end
    // overcurrent timer and trip
    if (over) begin
      if (st_q.oc_count >= trip_delay_cycles) begin
        st_d.oc_trip = 1'b1;
      end else begin
        st_d.oc_count = st_q.oc_count + 16'h0001;
      end
    end else begin
      st_d.oc_count = 16'h0000;
    end
    // a clear only takes once the current is no longer above the limit
    if (trip_reset && !over) begin
      st_d.oc_trip = 1'b0;
    end
    // status word assembly
    st_d.status = status_next(status_low_in, out_freq, freq_low_limit, freq_high_limit,
                              start_active, st_q.sync2, over);
    // reported frequency scaled to the limit range
    st_d.freq_rep = to_frac(out_freq, freq_low_limit, freq_high_limit);
    // coasting and output stage
    st_d.coast = cif.coast;
    st_d.stage_en = ~cif.coast & ~st_d.oc_trip;
    // setting writes: panel only, serial refused
    if (serial_wr) begin
      st_d.rej = 1'b1;
    end else if (panel_wr) begin
      st_d.proto = drive_ctrl_pkg::proto_t'(wr_protocol);
      if (addr_ok(wr_protocol, wr_address)) begin
        st_d.addr = wr_address;
      end else begin
        st_d.rej = 1'b1;
        // an address left illegal by the new protocol falls back
        if (!addr_ok(wr_protocol, st_q.addr)) begin
          st_d.addr = drive_ctrl_pkg::ADDR_DEFAULT;
        end
      end
      nb = wr_baud;
      if (baud_ok(wr_protocol, nb)) begin
        st_d.baud = nb;
      end else begin
        st_d.rej = 1'b1;
        if (!baud_ok(wr_protocol, st_q.baud)) begin
          st_d.baud = drive_ctrl_pkg::BAUD_9600;
        end
      end
    end
    if (!rst_b) begin
      st_d = '0;
      st_d.sync1 = drive_ctrl_pkg::SYNC_RESET;
      st_d.sync2 = drive_ctrl_pkg::SYNC_RESET;
      st_d.coast_serial_n = 1'b1;
      st_d.proto = drive_ctrl_pkg::PROTO_NATIVE;
      st_d.addr = drive_ctrl_pkg::ADDR_DEFAULT;
      st_d.baud = drive_ctrl_pkg::BAUD_9600;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  // status and scaled values
  assign status_word = st_q.status;
  assign freq_report = st_q.freq_rep;
  assign ref_value = st_q.ref_val;
  assign reverse = st_q.rev;

  // coasting, output stage and trip
  assign coast_active = st_q.coast;
  assign stage_enable = st_q.stage_en;
  assign oc_trip = st_q.oc_trip;

  // active settings and write refusal
  assign protocol = st_q.proto;
  assign station_addr = st_q.addr;
  assign baud_code = st_q.baud;
  assign wr_reject = st_q.rej;
endmodule
`default_nettype wire

// [dscs_checker.sv]
// Purpose: concurrent checks on the drive serial control and status block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module dscs_checker (
  input wire logic sys_clk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic [15:0] out_freq, // frequency
  input wire logic start_active, // start
  input wire logic [15:0] out_current, // current
  input wire logic [15:0] output_current_limit, // limit
  input wire logic serial_wr, // link write
  input wire logic [15:0] status_word, // status
  input wire logic coast_active, // coasting
  input wire logic stage_enable, // stage on
  input wire logic oc_trip, // trip
  input wire logic [1:0] protocol, // protocol
  input wire logic [7:0] station_addr, // address
  input wire logic [2:0] baud_code, // bit rate
  input wire logic wr_reject // refused
);
  // one clock, quiet in reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // status bits follow their causes one cycle on
  chk_spare_zero: assert property (status_word[12] == 1'b0) else $error("spare bit set");
  chk_run_bit: assert property (
    1 |=> status_word[11] == $past(start_active || out_freq != 16'h0000)) else $error("run bit");
  chk_cur_bit: assert property (
    1 |=> status_word[14] == $past(out_current > output_current_limit)) else $error("limit bit");
  chk_trip_cause: assert property (
    $rose(oc_trip) |-> $past(out_current > output_current_limit)) else $error("stray trip");
  // stage off with coasting or trip, same cycle
  chk_stage_gate: assert property (
    $past(rst_b) |-> stage_enable == (!coast_active && !oc_trip)) else $error("stage enable");
  // link writes are refused and change nothing
  chk_link_refused: assert property (
    serial_wr |-> ##[1:2] wr_reject) else $error("link write not refused");
  chk_link_keeps: assert property (
    serial_wr |=> $stable(station_addr) && $stable(baud_code)) else $error("setting changed");
  chk_baud_legal: assert property (
    baud_code <= 3'h5 && (protocol != 2'h1 || baud_code == 3'h5)
    && (protocol != 2'h2 || baud_code >= 3'h4)) else $error("bit rate illegal");
  chk_addr_legal: assert property (
    (protocol == 2'h0 && station_addr <= 8'h7E) || (protocol == 2'h1 && station_addr != 8'h00)
    || (protocol == 2'h2 && station_addr <= 8'h62)
    || (protocol == 2'h3 && station_addr != 8'h00 && station_addr <= 8'hF7))
    else $error("address illegal");
  // main scenarios reached
  cover property (oc_trip);
  cover property (coast_active);
  cover property (serial_wr ##1 wr_reject);
endmodule
bind drive_serial_control_status dscs_checker chk_u (.sys_clk, .rst_b, .out_freq, .start_active,
  .out_current, .output_current_limit, .serial_wr, .status_word, .coast_active, .stage_enable,
  .oc_trip, .protocol, .station_addr, .baud_code, .wr_reject);
`default_nettype wire

// [serial_master_model.sv]
// Purpose: serial bus master model sending telegrams to the drive
// Assumes: changes its lines just after the falling clock edge
// Notes: idle lines carry the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
  input wire logic sys_clk, // system clock
  output logic cw_valid, // telegram strobe
  output logic [15:0] ctrl_word, // control word
  output logic [15:0] serial_ref, // signed reference
  output logic serial_wr // setting write over the link
);
  // quiet lines before the first telegram
  initial begin
    cw_valid = 1'b0;
    serial_wr = 1'b0;
    ctrl_word = 16'h0000;
    serial_ref = 16'h0000;
  end
  // one telegram; reverse speed goes as two's complement
  task automatic send(input logic [15:0] cw, input logic [15:0] mag, input logic neg);
    @(negedge sys_clk);
    ctrl_word = cw;
    serial_ref = neg ? ~mag + 16'h0001 : mag;
    cw_valid = 1'b1;
    @(negedge sys_clk);
    cw_valid = 1'b0;
    ctrl_word = ~ctrl_word;
    serial_ref = ~serial_ref;
  endtask
  // a setting write over the link
  task automatic link_write();
    @(negedge sys_clk);
    serial_wr = 1'b1;
    @(negedge sys_clk);
    serial_wr = 1'b0;
  endtask
endmodule
`default_nettype wire

// [drive_serial_control_status_test.sv]
// Purpose: self-checking bench for the drive serial control and status block
// Assumes: inputs change on the falling edge of sys_clk
// Notes: a master model sends telegrams; the bench drives pins and panel writes
`timescale 1ns/1ns
`default_nettype none
module drive_serial_control_status_test;
  logic sys_clk, rst_b = 1'b0, start_active = 1'b0, trip_reset = 1'b0, panel_wr = 1'b0;
  logic coast_term_n_pin = 1'b1, cw_valid, serial_wr, reverse, coast_active, stage_enable;
  logic oc_trip, wr_reject, rj, ex;
  logic [1:0] coast_sel = 2'h3, wr_protocol = 2'h0, protocol;
  logic [2:0] wr_baud = 3'h5, baud_code;
  logic [4:0] pins = 5'h00;
  logic [7:0] wr_address = 8'h01, station_addr;
  logic [9:0] status_low_in = 10'h303;
  logic [15:0] out_freq = 16'h0019, freq_low_limit = 16'h0000, freq_high_limit = 16'h0032;
  logic [15:0] out_current = 16'h0000, output_current_limit = 16'h0064, ref_min = 16'h0000;
  logic [15:0] ref_max = 16'h03E8, trip_delay_cycles = 16'h0005, ctrl_word, serial_ref;
  logic [15:0] status_word, freq_report, ref_value;
  int n_errors = 0;
  int checks_done = 0;
  drive_serial_control_status uut (.sys_clk, .rst_b, .status_low_in, .out_freq, .freq_low_limit,
    .freq_high_limit, .start_active, .volt_low_pin(pins[0]), .volt_high_pin(pins[1]),
    .out_current, .output_current_limit, .trip_delay_cycles, .trip_reset,
    .motor_hot_pin(pins[2]), .conv_hot_pin(pins[3]), .thermistor_hot_pin(pins[4]), .cw_valid,
    .ctrl_word, .serial_ref, .ref_min, .ref_max, .coast_term_n_pin, .coast_sel, .panel_wr,
    .serial_wr, .wr_protocol, .wr_address, .wr_baud, .status_word, .freq_report, .ref_value,
    .reverse, .coast_active, .stage_enable, .oc_trip, .protocol, .station_addr, .baud_code,
    .wr_reject);
  serial_master_model mst (.sys_clk, .cw_valid, .ctrl_word, .serial_ref, .serial_wr);
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // panel write, then settings and refusal compared
  task automatic setw(input logic [1:0] p, input logic [7:0] a, input logic [2:0] b,
      input logic [7:0] ea, input logic [2:0] eb, input logic er);
    @(negedge sys_clk);
    wr_protocol = p;
    wr_address = a;
    wr_baud = b;
    panel_wr = 1'b1;
    @(negedge sys_clk);
    panel_wr = 1'b0;
    rj = wr_reject;
    @(negedge sys_clk);
    rj = rj | wr_reject;
    chk({protocol, station_addr, baud_code, 2'h0, rj}, {p, ea, eb, 2'h0, er});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    step(6);
    rst_b = 1'b1;
    step(4);
    chk({protocol, station_addr, baud_code, 3'h0}, 16'h0068);
    chk(status_word, 16'h0F03);
    chk(freq_report, 16'h2000);
    out_freq = 16'h0032;
    step(2);
    chk(status_word, 16'h0B03);
    chk(freq_report, 16'h4000);
    out_freq = 16'h0000;
    step(2);
    chk(status_word, 16'h0303);
    chk(freq_report, 16'h0000);
    start_active = 1'b1;
    step(2);
    chk(status_word, 16'h0B03);
    for (int i = 0; i < 5; i++) begin
      pins = 5'h01 << i;
      step(4);
      chk(status_word, (i < 2) ? 16'h2B03 : 16'h8B03);
    end
    pins = 5'h00;
    out_current = 16'h0065;
    step(3);
    chk({status_word[15:1], oc_trip}, 16'h4B02);
    step(8);
    chk({14'h0, oc_trip, stage_enable}, 16'h0002);
    trip_reset = 1'b1;
    step(2);
    chk({15'h0, oc_trip}, 16'h0001);
    out_current = 16'h0064;
    step(3);
    trip_reset = 1'b0;
    chk({status_word[15:2], oc_trip, stage_enable}, 16'h0B01);
    mst.send(16'h047F, 16'h2000, 1'b0);
    step(1);
    chk({reverse, ref_value[14:0]}, 16'h01F4);
    mst.send(16'h047F, 16'h2000, 1'b1);
    step(1);
    chk({reverse, ref_value[14:0]}, 16'h81F4);
    mst.send(16'h047F, 16'h4000, 1'b0);
    step(1);
    chk(ref_value, 16'h03E8);
    mst.send(16'h037F, 16'h2000, 1'b1);
    step(1);
    chk({reverse, ref_value[14:0]}, 16'h03E8);
    for (int k = 0; k < 16; k++) begin
      coast_sel = k[3:2];
      coast_term_n_pin = k[1];
      mst.send({12'h047, k[0], 3'h7}, 16'h0000, 1'b0);
      step(4);
      case (k[3:2])
        2'h0: ex = !k[1];
        2'h1: ex = !k[0];
        2'h2: ex = !k[1] && !k[0];
        default: ex = !k[1] || !k[0];
      endcase
      chk({14'h0, coast_active, stage_enable}, {14'h0, ex, !ex});
    end
    setw(2'h0, 8'h7E, 3'h0, 8'h7E, 3'h0, 1'b0);
    setw(2'h0, 8'h7F, 3'h2, 8'h7E, 3'h2, 1'b1);
    setw(2'h2, 8'h63, 3'h5, 8'h01, 3'h5, 1'b1);
    setw(2'h1, 8'h00, 3'h5, 8'h01, 3'h5, 1'b1);
    setw(2'h1, 8'hFF, 3'h5, 8'hFF, 3'h5, 1'b0);
    setw(2'h2, 8'h62, 3'h4, 8'h62, 3'h4, 1'b0);
    setw(2'h2, 8'h63, 3'h3, 8'h62, 3'h4, 1'b1);
    setw(2'h3, 8'hF8, 3'h1, 8'h62, 3'h1, 1'b1);
    setw(2'h3, 8'hF7, 3'h1, 8'hF7, 3'h1, 1'b0);
    setw(2'h1, 8'h05, 3'h3, 8'h05, 3'h5, 1'b1);
    setw(2'h0, 8'h10, 3'h6, 8'h10, 3'h5, 1'b1);
    wr_address = 8'h20;
    wr_baud = 3'h3;
    mst.link_write();
    chk({15'h0, wr_reject}, 16'h0001);
    step(2);
    chk({station_addr, 5'h00, baud_code}, 16'h1005);
    // second reset in mid-run brings the defaults back
    rst_b = 1'b0;
    step(2);
    rst_b = 1'b1;
    step(3);
    chk({protocol, station_addr, baud_code, coast_active, stage_enable, oc_trip},
        16'h006A);
    report_and_stop();
  end
endmodule
`default_nettype wire
